// ==== rtl/tidsl_core.sv ====
// four-channel set point engine: fine and coarse tables, index math, value registers
// assumes temperature and conversion strobe come from an adc on the same clock
`timescale 1ns/1ps
module tidsl_core
  import tidsl_pkg::*;
(
  input  wire logic                                  clock_i,
  input  wire logic                                  rstn_i,
  input  wire logic [15:0]                           temp_i,
  input  wire logic                                  conv_done_i,
  input  wire logic [tidsl_pkg::NUM_CH-1:0]          table_mode_i,
  input  wire logic                                  reg_wr_i,
  input  wire logic                                  reg_rd_i,
  input  wire logic [7:0]                            reg_page_i,
  input  wire logic [7:0]                            reg_addr_i,
  input  wire logic [7:0]                            reg_wdata_i,
  output logic      [7:0]                            reg_rdata_o,
  input  wire logic                                  value_wr_i,
  input  wire logic [1:0]                            value_ch_i,
  input  wire logic [tidsl_pkg::VALUE_W-1:0]         value_data_i,
  output logic      [tidsl_pkg::NUM_CH-1:0][tidsl_pkg::VALUE_W-1:0] dac_value_o,
  output logic      [5:0]                            temp_table_index_o,
  output logic      [2:0]                            offset_index_o
);
  import tidsl_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [NUM_CH-1:0][FINE_DEPTH-1:0][7:0]   fine_temp_table;
    logic [NUM_CH-1:0][COARSE_DEPTH-1:0][7:0] coarse_offset_table;
    logic [NUM_CH-1:0][VALUE_W-1:0]           value;
    logic [5:0]                               temp_table_index;
    logic [2:0]                               offset_index;
    logic [7:0]                               rdata;
  } tidsl_state_s;

  tidsl_state_s          st;
  tidsl_state_s          next_st;
  logic signed [8:0]     tw;
  logic signed [8:0]     dfine;
  logic signed [8:0]     dcoarse;
  logic [5:0]            fidx;
  logic [2:0]            cidx;
  logic [NUM_CH-1:0][10:0]        sum_w;
  logic [NUM_CH-1:0][VALUE_W-1:0] setpt;
  logic                  page_ok;
  logic [1:0]            ch;
  logic                  fine_hit;
  logic                  coarse_hit;
  logic [5:0]            fine_off;
  logic [2:0]            coarse_off;

  // ==========================================================================
  // index math; only the whole-degree byte matters, the fraction byte temp_i[7:0] is ignored
  assign tw      = {temp_i[15], temp_i[15:8]};
  assign dfine   = tw - ((tw < T_FINE_KNEE) ? T_FINE_START : T_FINE_KNEE);
  assign dcoarse = tw - T_COARSE_START;

  // fine band select, 4-degree then 2-degree steps
  always_comb
  begin
    if (tw < T_FINE_FIRST)
      fidx = '0;
    else if (tw < T_FINE_KNEE)
      fidx = dfine[7:2];
    else if (tw >= T_FINE_CLAMP)
      fidx = FINE_LAST_IDX;
    else
      fidx = FINE_KNEE_IDX + dfine[6:1];
  end

  // coarse band select, 16-degree steps with clamps at both ends
  always_comb
  begin
    if (tw < T_COARSE_START)
      cidx = '0;
    else if (tw >= T_COARSE_CLAMP)
      cidx = COARSE_LAST_IDX;
    else
      cidx = 3'h1 + dcoarse[6:4];
  end

  // ==========================================================================
  // set point per channel; 11-bit sum cannot wrap, so saturation is exact
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      sum_w[c] = {3'h0, st.fine_temp_table[c][fidx]}
               + {1'h0, st.coarse_offset_table[c][cidx], 2'h0};
      setpt[c] = (sum_w[c] > {1'h0, VALUE_MAX}) ? VALUE_MAX : sum_w[c][9:0];
    end
  end

  // ==========================================================================
  // register decode: page 04h..07h picks the channel's table pair
  assign page_ok    = (reg_page_i >= PAGE_FIRST) && (reg_page_i <= PAGE_LAST);
  assign ch         = 2'(reg_page_i - PAGE_FIRST);
  assign fine_hit   = page_ok && (reg_addr_i >= FINE_BASE) && (reg_addr_i <= FINE_LAST);
  assign coarse_hit = page_ok && (reg_addr_i >= COARSE_BASE);
  assign fine_off   = 6'(reg_addr_i - FINE_BASE);
  assign coarse_off = 3'(reg_addr_i - COARSE_BASE);

  // next state: table writes, reads, direct value writes, conversion loads
  always_comb
  begin
    next_st = st;
    if (reg_wr_i && fine_hit)
      next_st.fine_temp_table[ch][fine_off] = reg_wdata_i;
    if (reg_wr_i && coarse_hit)
      next_st.coarse_offset_table[ch][coarse_off] = reg_wdata_i;
    // unmapped offsets read as zero
    if (reg_rd_i)
    begin
      if (fine_hit)
        next_st.rdata = st.fine_temp_table[ch][fine_off];
      else if (coarse_hit)
        next_st.rdata = st.coarse_offset_table[ch][coarse_off];
      else
        next_st.rdata = 8'h00;
    end
    // a direct write is dropped while the channel follows the table
    if (value_wr_i && !table_mode_i[value_ch_i])
      next_st.value[value_ch_i] = value_data_i;
    if (conv_done_i)
    begin
      next_st.temp_table_index = fidx;
      next_st.offset_index     = cidx;
      for (int c = 0; c < NUM_CH; c++)
        if (table_mode_i[c])
          next_st.value[c] = setpt[c];
    end
  end

  // single register stage for all state; tables reset to factory blank
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign reg_rdata_o        = st.rdata;
  assign dac_value_o        = st.value;
  assign temp_table_index_o = st.temp_table_index;
  assign offset_index_o     = st.offset_index;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  a_setpoint_sum: assert property (conv_done_i && table_mode_i[0] && sum_w[0] <= 11'h3FF
    |=> dac_value_o[0] == $past(st.fine_temp_table[0][fidx])
        + 10'($past(st.coarse_offset_table[0][cidx]) * 4))
    else $error("set point is not fine plus four offsets");

  a_fine_step: assert property (conv_done_i && tw >= -9'sh024 && tw < 9'sh038
    |=> temp_table_index_o == 6'(($past(tw) + 9'sh028) >>> 2))
    else $error("fine index wrong in 4-degree span");

  a_fine_clamp: assert property (conv_done_i && tw >= 9'sh066
    |=> temp_table_index_o == 6'h2F)
    else $error("fine index not clamped at top");

  a_fine_first: assert property (conv_done_i && tw < -9'sh024
    |=> temp_table_index_o == 6'h00)
    else $error("cold temperature not on first fine entry");

  a_coarse_top: assert property (conv_done_i && tw >= 9'sh058
    |=> offset_index_o == 3'h7)
    else $error("coarse index not clamped at top");

  a_coarse_low: assert property (conv_done_i && tw >= -9'sh008 && tw < 9'sh008
    |=> offset_index_o == 3'h1)
    else $error("coarse second band wrong");

  a_page_map: assert property (reg_wr_i && reg_page_i == 8'h05 && reg_addr_i == 8'h80
    ##1 reg_rd_i && !reg_wr_i && reg_page_i == 8'h05 && reg_addr_i == 8'h80
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("table byte not read back from its page");

  a_mode_load: assert property (conv_done_i && table_mode_i[2]
    |=> dac_value_o[2] == $past(setpt[2]))
    else $error("table mode channel not loaded after conversion");

  a_mode_hold: assert property (!table_mode_i[1] && !(value_wr_i && value_ch_i == 2'h1)
    |=> $stable(dac_value_o[1]))
    else $error("manual channel changed without a write");

  a_index_range: assert property (conv_done_i |=> temp_table_index_o <= 6'h2F)
    else $error("fine index beyond table");

  a_sat_top: assert property (conv_done_i && table_mode_i[3] && sum_w[3] > 11'h3FF
    |=> dac_value_o[3] == 10'h3FF)
    else $error("overflowing set point not saturated");

  // ==========================================================================
  // band and port checks; expected indices are rebuilt from degrees, not from fidx/cidx
  a_fine_knee: assert property (conv_done_i && tw >= 9'sh038 && tw < 9'sh066
    |=> temp_table_index_o == 6'(24 + (($past(tw) - 9'sh038) >>> 1)))
    else $error("fine index wrong in 2-degree span");

  a_coarse_mid: assert property (conv_done_i && tw >= -9'sh008 && tw < 9'sh058
    |=> offset_index_o == 3'(1 + (($past(tw) + 9'sh008) >>> 4)))
    else $error("coarse index wrong in 16-degree span");

  a_coarse_first: assert property (conv_done_i && tw < -9'sh008
    |=> offset_index_o == 3'h0)
    else $error("cold temperature not on first coarse entry");

  // a read outside the four pages must not leak a stale table byte
  a_read_zero: assert property (reg_rd_i && (reg_page_i < 8'h04 || reg_page_i > 8'h07)
    |=> reg_rdata_o == 8'h00)
    else $error("read outside the table pages not zero");

  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");

  a_manual_write: assert property (value_wr_i && !table_mode_i[value_ch_i]
    |=> dac_value_o[$past(value_ch_i)] == $past(value_data_i))
    else $error("manual channel did not take its direct write");

endmodule // tidsl_core

// ==== rtl/tidsl_pkg.sv ====
// constants shared by the temperature-indexed set point table block
// assumes an 8-bit paged register port driven by a serial front end on the same clock
// ==========================================================================
// Operation
// - set point is fine byte plus four offsets
// - fine index steps every 4 degrees from -40
// - 2-degree steps from 56, clamp at 102
// - first fine entry serves below -36 degrees
// - coarse entry per 16 degrees, last at +88
// - first coarse entry below -8, second -8..+7
// - four table pairs, pages 04h-07h per channel
// - table mode loads value after each conversion
// - table mode clear: software writes value directly
// - index from left-justified signed temperature result
package tidsl_pkg;

  // ========================================================================
  // geometry
  localparam int          NUM_CH       = 4;
  localparam int          FINE_DEPTH   = 48;
  localparam int          COARSE_DEPTH = 8;
  localparam int          VALUE_W      = 10;

  // ========================================================================
  // register map: page selects the channel, offset selects the entry
  localparam logic [7:0]  PAGE_FIRST   = 8'h04;
  localparam logic [7:0]  PAGE_LAST    = 8'h07;
  localparam logic [7:0]  FINE_BASE    = 8'h80;
  localparam logic [7:0]  FINE_LAST    = 8'hAF;
  localparam logic [7:0]  COARSE_BASE  = 8'hF8;
  localparam logic [7:0]  TABLE_RESET  = 8'h00;
  localparam logic [9:0]  VALUE_RESET  = 10'h000;
  localparam logic [9:0]  VALUE_MAX    = 10'h3FF;
  localparam int          OFFSET_SHIFT = 2;

  // ========================================================================
  // temperature breakpoints in whole degrees, 9-bit signed, then the unsigned table indices they select
  localparam logic signed [8:0] T_FINE_START   = -9'sh028;
  localparam logic signed [8:0] T_FINE_FIRST   = -9'sh024;
  localparam logic signed [8:0] T_FINE_KNEE    =  9'sh038;
  localparam logic signed [8:0] T_FINE_CLAMP   =  9'sh066;
  localparam logic signed [8:0] T_COARSE_START = -9'sh008;
  localparam logic signed [8:0] T_COARSE_CLAMP =  9'sh058;
  localparam logic [5:0]        FINE_KNEE_IDX  = 6'h18;
  localparam logic [5:0]        FINE_LAST_IDX  = 6'h2F;
  localparam logic [2:0]        COARSE_LAST_IDX = 3'h7;

endpackage

// ==== tb/tidsl_core_tb.sv ====
// self-checking bench for the temperature-indexed set point engine
// assumes the paged byte port, conversion strobe and direct writes are driven here
`timescale 1ns/1ps
module tidsl_core_tb;
  import tidsl_pkg::*;
  // ========================================================================
  // stimulus and observation
  logic                                clock_i      = 1'b0;
  logic                                rstn_i       = 1'b0;
  logic [15:0]                         temp_i       = 16'h0000;
  logic                                conv_done_i  = 1'b0;
  logic [NUM_CH-1:0]                   table_mode_i = 4'hB;
  logic                                reg_wr_i     = 1'b0;
  logic                                reg_rd_i     = 1'b0;
  logic [7:0]                          reg_page_i   = 8'h00;
  logic [7:0]                          reg_addr_i   = 8'h00;
  logic [7:0]                          reg_wdata_i  = 8'h00;
  logic [7:0]                          reg_rdata_o;
  logic                                value_wr_i   = 1'b0;
  logic [1:0]                          value_ch_i   = 2'h0;
  logic [VALUE_W-1:0]                  value_data_i = 10'h000;
  logic [NUM_CH-1:0][VALUE_W-1:0]      dac_value_o;
  logic [5:0]                          temp_table_index_o;
  logic [2:0]                          offset_index_o;
  int                                  fails = 0;
  int                                  cmp_count = 0;
  int                                  temps [16] = '{-41, -37, -36, -33, 55, 56, 57, 101,
                                                      102, 120, -9, -8, 7, 8, 87, 88};

  // ========================================================================
  // clock, device under test, watchdog
  always #5 clock_i = ~clock_i;

  tidsl_core u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .temp_i(temp_i),
    .conv_done_i(conv_done_i), .table_mode_i(table_mode_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_page_i(reg_page_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .value_wr_i(value_wr_i),
    .value_ch_i(value_ch_i), .value_data_i(value_data_i), .dac_value_o(dac_value_o),
    .temp_table_index_o(temp_table_index_o), .offset_index_o(offset_index_o));

  // the tests need well under a thousand cycles, so this only trips on a hang
  initial
  begin
    #200000;
    fails++;
    complete_run();
  end

  // ========================================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock_i);
    reg_wr_i <= 1'b1; reg_page_i <= page; reg_addr_i <= addr; reg_wdata_i <= data;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data lands at the read edge and then holds, so sampling later is safe
  task automatic rd(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clock_i);
    reg_rd_i <= 1'b1; reg_page_i <= page; reg_addr_i <= addr;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(posedge clock_i);
    #1 chk({8'h00, reg_rdata_o}, {8'h00, exp}, "read data");
  endtask

  task automatic conv(input int t);
    @(posedge clock_i);
    temp_i <= {t[7:0], 8'h5F}; conv_done_i <= 1'b1;
    @(posedge clock_i);
    conv_done_i <= 1'b0;
    #1;
  endtask

  task automatic vwr(input logic [1:0] ch, input logic [9:0] data);
    @(posedge clock_i);
    value_wr_i <= 1'b1; value_ch_i <= ch; value_data_i <= data;
    @(posedge clock_i);
    value_wr_i <= 1'b0;
    #1;
  endtask

  // expected indices worked out from the band edges in whole degrees
  function automatic logic [15:0] fine_idx(input int t);
    if (t < -36) return 16'd0;
    if (t < 56) return 16'((t + 40) / 4);
    if (t < 102) return 16'(24 + (t - 56) / 2);
    return 16'd47;
  endfunction

  function automatic logic [15:0] coarse_idx(input int t);
    if (t < -8) return 16'd0;
    if (t >= 88) return 16'd7;
    return 16'(1 + (t + 8) / 16);
  endfunction

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ========================================================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    chk({6'h00, dac_value_o[0]}, 16'h0000, "value after reset");
    rd(8'h04, 8'hF8, 8'h00);
    // each page keeps its own bytes; outside pages and offsets read zero
    for (int c = 0; c < NUM_CH; c++) wr(8'(4 + c), 8'hAF, 8'(8'hA0 + c));
    for (int c = 0; c < NUM_CH; c++) rd(8'(4 + c), 8'hAF, 8'(8'hA0 + c));
    wr(8'h03, 8'h80, 8'h77);
    wr(8'h04, 8'hB0, 8'h77);
    rd(8'h03, 8'h80, 8'h00);
    rd(8'h04, 8'hB0, 8'h00);
    rd(8'h04, 8'h80, 8'h00);
    // write then read of one byte on consecutive edges, as the port allows
    @(posedge clock_i);
    reg_wr_i    <= 1'b1;
    reg_page_i  <= 8'h05;
    reg_addr_i  <= 8'h80;
    reg_wdata_i <= 8'h5A;
    @(posedge clock_i);
    reg_wr_i    <= 1'b0;
    reg_rd_i    <= 1'b1;
    @(posedge clock_i);
    reg_rd_i    <= 1'b0;
    #1 chk({8'h00, reg_rdata_o}, 16'h005A, "back-to-back read");
    // band edges of both tables, lower result bits set to show they are ignored
    foreach (temps[i])
    begin
      conv(temps[i]);
      chk({10'h000, temp_table_index_o}, fine_idx(temps[i]), "fine index");
      chk({13'h0000, offset_index_o}, coarse_idx(temps[i]), "coarse index");
    end
    // 25 degrees selects fine entry 16 (90h) and coarse entry 3 (FBh)
    wr(8'h04, 8'h90, 8'h12); wr(8'h04, 8'hFB, 8'h20);
    wr(8'h05, 8'h90, 8'hFF); wr(8'h05, 8'hFB, 8'hFF);
    wr(8'h06, 8'h90, 8'h33); wr(8'h06, 8'hFB, 8'h01);
    wr(8'h07, 8'h90, 8'h40); wr(8'h07, 8'hFB, 8'h01);
    vwr(2'h2, 10'h2AA);
    chk({6'h00, dac_value_o[2]}, 16'h02AA, "manual write");
    conv(25);
    chk({6'h00, dac_value_o[0]}, 16'h0092, "set point ch0");
    chk({6'h00, dac_value_o[1]}, 16'h03FF, "saturated ch1");
    chk({6'h00, dac_value_o[2]}, 16'h02AA, "manual ch2 kept");
    chk({6'h00, dac_value_o[3]}, 16'h0044, "set point ch3");
    vwr(2'h0, 10'h155);
    chk({6'h00, dac_value_o[0]}, 16'h0092, "table channel refuses write");
    // ch3 offset pushed past full scale, then ch2 follows the table and the rest go manual
    wr(8'h07, 8'hFB, 8'hFF);
    conv(25);
    chk({6'h00, dac_value_o[3]}, 16'h03FF, "saturated ch3");
    @(posedge clock_i);
    table_mode_i <= 4'h4;
    conv(25);
    chk({6'h00, dac_value_o[2]}, 16'h0037, "set point ch2");
    chk({6'h00, dac_value_o[0]}, 16'h0092, "manual ch0 kept");
    chk({6'h00, dac_value_o[1]}, 16'h03FF, "manual ch1 kept");
    vwr(2'h0, 10'h155);
    chk({6'h00, dac_value_o[0]}, 16'h0155, "manual ch0 written");
    complete_run();
  end
endmodule // tidsl_core_tb
